// ### hdl/switch_panel_can_framer.sv
// module: membrane switch panel logic with legacy CAN framing
`timescale 1ns/1ps
`default_nettype none
//Operation
// - per switch on/off delay, zero acts at once
// - local green lights while switch pressed
// - received green follows remote output on
// - bus error forces all red on
// - local red off; received red shows fault
// - eight extra export packages, own identifiers
// - value over 255 goes as word
// - export value zero marks level unused
// - group activation cancels the other members
// - repress turns off only if empty allowed
// - one group per switch
// - legacy option adds bit-mapped transmit frame
// - absolute bit is byte times eight plus bit
// - switches 1-20 in bytes 7, 6, 5
// - feedback accepted only with 0x0a in byte 0
// - received green follows bytes 3, 2, 1
// - greens 1-20 in bytes 3, 2, 1
// - 11-bit identifiers kept within 7ff
// - received red follows bytes 7, 6, 5
module switch_panel_can_framer #(
    parameter int unsigned TICK_CYC = switch_panel_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // switch pins, high while pressed
    input  wire logic [19:0]             sw_pressed,
    // can controller receive side
    input  wire logic                    rx_valid,
    input  wire switch_panel_pkg::frame_s rx_frame,
    input  wire logic                    bus_error,
    // can controller transmit side
    output switch_panel_pkg::frame_s     tx_frame,
    output logic                         tx_valid,
    input  wire logic                    tx_ready,
    // indicators and state
    output logic [19:0]                  green_led,
    output logic [19:0]                  red_led,
    output logic [19:0]                  switch_state
);
    import switch_panel_pkg::*;

    // ****************************************
    // configuration registers
    // ****************************************
    logic        pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, rd_mux;
    logic        hit, wr_en;
    logic        leg_en_ff;
    logic [29:0] pri_id_ff, sec_id_ff, txid_ff;
    logic [19:0] gsel_ff, gsec_ff, rsel_ff, rsec_ff, nosel_ff;
    logic [4:0]  idx_ff;
    logic [2:0]  xsel_ff;
    logic [4:0]  grp_ff [NSW];
    logic [7:0]  don_ff [NSW];
    logic [7:0]  doff_ff [NSW];
    logic [29:0] xid_ff [NPKG];
    logic [15:0] xon_ff [NPKG];
    logic [15:0] xoff_ff [NPKG];
    logic [4:0]  xsw_ff [NPKG];
    logic [7:0]  xen_ff;
    logic        idx_ok;

    // 11-bit identifiers drop anything above 7ff
    function automatic logic [29:0] id_fix(input logic [31:0] w);
        id_fix = w[ID_EXT_BIT] ? {1'b1, w[28:0]} : {1'b0, w[28:0] & ID11_MAX};
    endfunction : id_fix

    assign wr_en  = psel & penable & pready_ff & pwrite;
    assign idx_ok = idx_ff < 5'(NSW);

    // one wait state keeps pready and prdata straight off flops
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff <= psel & penable & ~pready_ff;
            if (psel & penable & ~pready_ff) begin
                pslverr_ff <= ~hit;
                prdata_ff  <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            leg_en_ff <= 1'b0;
            pri_id_ff <= 30'h0;
            sec_id_ff <= 30'h0;
            txid_ff   <= 30'h0;
            gsel_ff   <= 20'h0;
            gsec_ff   <= 20'h0;
            rsel_ff   <= 20'h0;
            rsec_ff   <= 20'h0;
            nosel_ff  <= NOSEL_RST;
            idx_ff    <= 5'h0;
            xsel_ff   <= 3'h0;
        end else if (wr_en) begin
            case (paddr)
                CTRL_OFS:  leg_en_ff <= pwdata[CTRL_LEG_BIT];
                RXPRI_OFS: pri_id_ff <= id_fix(pwdata);
                RXSEC_OFS: sec_id_ff <= id_fix(pwdata);
                TXID_OFS:  txid_ff   <= id_fix(pwdata);
                GSEL_OFS:  gsel_ff   <= pwdata[19:0];
                GSEC_OFS:  gsec_ff   <= pwdata[19:0];
                RSEL_OFS:  rsel_ff   <= pwdata[19:0];
                RSEC_OFS:  rsec_ff   <= pwdata[19:0];
                IDX_OFS:   idx_ff    <= pwdata[4:0];
                NOSEL_OFS: nosel_ff  <= pwdata[19:0];
                XSEL_OFS:  xsel_ff   <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // per switch tables, reached through the index register
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NSW; i++) begin
                grp_ff[i]  <= 5'(i);
                don_ff[i]  <= 8'h0;
                doff_ff[i] <= 8'h0;
            end
        end else if (wr_en && idx_ok) begin
            // a single group field per switch keeps membership unique
            if (paddr == GRP_OFS && pwdata[4:0] < 5'(NSW))
                grp_ff[idx_ff] <= pwdata[4:0];
            if (paddr == DLY_OFS) begin
                don_ff[idx_ff]  <= pwdata[7:0];
                doff_ff[idx_ff] <= pwdata[DLY_OFF_LSB +: 8];
            end
        end
    end

    // extra export package table
    always_ff @(posedge clk) begin
        if (srst) begin
            xen_ff <= 8'h0;
            for (int k = 0; k < NPKG; k++) begin
                xid_ff[k]  <= 30'h0;
                xon_ff[k]  <= 16'h0;
                xoff_ff[k] <= 16'h0;
                xsw_ff[k]  <= 5'h0;
            end
        end else if (wr_en) begin
            if (paddr == XID_OFS)
                xid_ff[xsel_ff] <= id_fix(pwdata);
            if (paddr == XVAL_OFS) begin
                xoff_ff[xsel_ff] <= pwdata[15:0];
                xon_ff[xsel_ff]  <= pwdata[XVAL_ON_LSB +: 16];
            end
            if (paddr == XSW_OFS) begin
                xsw_ff[xsel_ff] <= pwdata[4:0];
                xen_ff[xsel_ff] <= pwdata[XSW_EN_BIT] & (pwdata[4:0] < 5'(NSW));
            end
        end
    end

    logic [19:0] active_ff, green_ff, red_ff;

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            CTRL_OFS:  rd_mux[CTRL_LEG_BIT] = leg_en_ff;
            RXPRI_OFS: rd_mux = {pri_id_ff[29], 2'b0, pri_id_ff[28:0]};
            RXSEC_OFS: rd_mux = {sec_id_ff[29], 2'b0, sec_id_ff[28:0]};
            TXID_OFS:  rd_mux = {txid_ff[29], 2'b0, txid_ff[28:0]};
            GSEL_OFS:  rd_mux[19:0] = gsel_ff;
            GSEC_OFS:  rd_mux[19:0] = gsec_ff;
            RSEL_OFS:  rd_mux[19:0] = rsel_ff;
            RSEC_OFS:  rd_mux[19:0] = rsec_ff;
            IDX_OFS:   rd_mux[4:0] = idx_ff;
            GRP_OFS:   rd_mux[4:0] = idx_ok ? grp_ff[idx_ff] : 5'h0;
            DLY_OFS:   rd_mux[15:0] = idx_ok ? {doff_ff[idx_ff], don_ff[idx_ff]} : 16'h0;
            NOSEL_OFS: rd_mux[19:0] = nosel_ff;
            XSEL_OFS:  rd_mux[2:0] = xsel_ff;
            XID_OFS:   rd_mux = {xid_ff[xsel_ff][29], 2'b0, xid_ff[xsel_ff][28:0]};
            XVAL_OFS:  rd_mux = {xon_ff[xsel_ff], xoff_ff[xsel_ff]};
            XSW_OFS:   rd_mux[8:0] = {xen_ff[xsel_ff], 3'b0, xsw_ff[xsel_ff]};
            STAT_OFS:  rd_mux[19:0] = active_ff;
            GLED_OFS:  rd_mux[19:0] = green_ff;
            RLED_OFS:  rd_mux[19:0] = red_ff;
            default:   hit = 1'b0;
        endcase
    end

    // ****************************************
    // switch inputs and delay tick
    // ****************************************
    logic [19:0] s1_ff, s2_ff, s3_ff, lvl_ff, press_now;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic        tick_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_ff  <= 20'h0;
            s2_ff  <= 20'h0;
            s3_ff  <= 20'h0;
            lvl_ff <= 20'h0;
        end else begin
            s1_ff  <= sw_pressed;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (lvl_ff & (s2_ff ^ s3_ff));
        end
    end

    assign press_now = s2_ff & s3_ff & ~lvl_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else begin
            tick_ff     <= tick_cnt_ff == TICK_W'(TICK_CYC - 1);
            tick_cnt_ff <= (tick_cnt_ff == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt_ff + 1'b1;
        end
    end

    // ****************************************
    // delays, latching and groups
    // ****************************************
    logic [19:0] pon_ff, poff_ff, on_now, off_now, on_keep, mate_act, nxt_active, cnt_done;
    logic [7:0]  cnt_ff [NSW];

    always_ff @(posedge clk) begin
        if (srst) begin
            pon_ff  <= 20'h0;
            poff_ff <= 20'h0;
            for (int i = 0; i < NSW; i++)
                cnt_ff[i] <= 8'h0;
        end else begin
            for (int i = 0; i < NSW; i++) begin
                if (press_now[i] && !active_ff[i]) begin
                    pon_ff[i]  <= 1'b1;
                    poff_ff[i] <= 1'b0;
                    cnt_ff[i]  <= don_ff[i];
                end else if (press_now[i] && nosel_ff[grp_ff[i]]) begin
                    pon_ff[i]  <= 1'b0;
                    poff_ff[i] <= 1'b1;
                    cnt_ff[i]  <= doff_ff[i];
                end else if (on_now[i] || off_now[i]) begin
                    pon_ff[i]  <= 1'b0;
                    poff_ff[i] <= 1'b0;
                end else if (tick_ff && cnt_ff[i] != 8'h0) begin
                    cnt_ff[i] <= cnt_ff[i] - 8'h1;
                end
            end
        end
    end

    // a plain process, so the countdown itself wakes the decode
    always_comb begin
        for (int i = 0; i < NSW; i++)
            cnt_done[i] = cnt_ff[i] == 8'h0;
    end

    assign on_now  = pon_ff & ~poff_ff & cnt_done;
    assign off_now = poff_ff & cnt_done;

    // lower switch wins when two members fire together
    always_comb begin
        on_keep  = on_now;
        mate_act = 20'h0;
        for (int j = 0; j < NSW; j++) begin
            for (int i = 0; i < NSW; i++) begin
                if (i < j && on_now[i] && grp_ff[i] == grp_ff[j])
                    on_keep[j] = 1'b0;
                if (i != j && active_ff[i] && grp_ff[i] == grp_ff[j])
                    mate_act[j] = 1'b1;
            end
        end
        nxt_active = active_ff & ~off_now;
        for (int j = 0; j < NSW; j++)
            for (int i = 0; i < NSW; i++)
                if (i != j && on_keep[i] && grp_ff[i] == grp_ff[j])
                    nxt_active[j] = 1'b0;
        nxt_active = nxt_active | on_keep;
    end

    always_ff @(posedge clk) begin
        if (srst)
            active_ff <= 20'h0;
        else
            active_ff <= nxt_active;
    end

    // ****************************************
    // feedback receive and indicators
    // ****************************************
    logic [19:0] pri_on_ff, pri_flt_ff, sec_on_ff, sec_flt_ff;
    logic        rx_ok, rx_pri, rx_sec;
    logic [63:0] d;

    assign d      = rx_frame.data;
    assign rx_ok  = rx_valid && d[7:0] == RX_MAGIC;
    assign rx_pri = rx_ok && {rx_frame.ext, rx_frame.id} == pri_id_ff;
    assign rx_sec = rx_ok && {rx_frame.ext, rx_frame.id} == sec_id_ff;

    // byte n sits at data[8n+7:8n]
    always_ff @(posedge clk) begin
        if (srst) begin
            pri_on_ff  <= 20'h0;
            pri_flt_ff <= 20'h0;
            sec_on_ff  <= 20'h0;
            sec_flt_ff <= 20'h0;
        end else begin
            if (rx_pri) begin
                pri_on_ff  <= {d[11:8], d[23:16], d[31:24]};
                pri_flt_ff <= {d[43:40], d[55:48], d[63:56]};
            end
            if (rx_sec) begin
                sec_on_ff  <= {d[11:8], d[23:16], d[31:24]};
                sec_flt_ff <= {d[43:40], d[55:48], d[63:56]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            green_ff <= 20'h0;
            red_ff   <= 20'h0;
        end else begin
            green_ff <= (~gsel_ff & lvl_ff)
                      | (gsel_ff & ~gsec_ff & pri_on_ff) | (gsel_ff & gsec_ff & sec_on_ff);
            red_ff   <= bus_error ? 20'hfffff
                      : rsel_ff & ((~rsec_ff & pri_flt_ff) | (rsec_ff & sec_flt_ff));
        end
    end

    // ****************************************
    // transmit scheduling
    // ****************************************
    logic        leg_pend_ff, tx_valid_ff, tx_leg_ff, load;
    logic [7:0]  xpend_ff, xset, xpick;
    logic [2:0]  xk;
    logic [15:0] xv;
    logic [19:0] chg;
    frame_s      tx_ff;

    assign chg  = nxt_active ^ active_ff;
    assign load = !tx_valid_ff || tx_ready;

    always_comb begin
        xset  = 8'h0;
        xpick = 8'h0;
        xk    = 3'h0;
        for (int k = 0; k < NPKG; k++) begin
            if (xen_ff[k] && chg[xsw_ff[k]])
                xset[k] = (nxt_active[xsw_ff[k]] ? xon_ff[k] : xoff_ff[k]) != 16'h0;
        end
        for (int k = NPKG - 1; k >= 0; k--) begin
            if (xpend_ff[k])
                xk = 3'(k);
        end
        xpick[xk] = load && !leg_pend_ff && xpend_ff[xk];
        xv        = active_ff[xsw_ff[xk]] ? xon_ff[xk] : xoff_ff[xk];
    end

    // a new change wins over the clear of the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            leg_pend_ff <= 1'b0;
            xpend_ff    <= 8'h0;
        end else begin
            leg_pend_ff <= (leg_pend_ff & ~load) | (leg_en_ff & |chg);
            xpend_ff    <= (xpend_ff & ~xpick) | xset;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_valid_ff <= 1'b0;
            tx_leg_ff   <= 1'b0;
            tx_ff       <= '0;
        end else if (load) begin
            tx_valid_ff <= leg_pend_ff || xpend_ff != 8'h0;
            tx_leg_ff   <= leg_pend_ff;
            tx_ff.data  <= 64'h0;
            if (leg_pend_ff) begin
                tx_ff.ext          <= txid_ff[29];
                tx_ff.id           <= txid_ff[28:0];
                tx_ff.dlc          <= LEG_DLC;
                tx_ff.data[63:56]  <= active_ff[7:0];
                tx_ff.data[55:48]  <= active_ff[15:8];
                tx_ff.data[43:40]  <= active_ff[19:16];
            end else begin
                tx_ff.ext <= xid_ff[xk][29];
                tx_ff.id  <= xid_ff[xk][28:0];
                if (xv > BYTE_MAX) begin
                    tx_ff.dlc        <= WORD_DLC;
                    tx_ff.data[15:0] <= {xv[7:0], xv[15:8]};
                end else begin
                    tx_ff.dlc       <= BYTE_DLC;
                    tx_ff.data[7:0] <= xv[7:0];
                end
            end
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign tx_frame     = tx_ff;
    assign tx_valid     = tx_valid_ff;
    assign green_led    = green_ff;
    assign red_led      = red_ff;
    assign switch_state = active_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence pri_fb_s;
        rx_pri && !bus_error ##1 1'b1;
    endsequence

    leg_pad_zero_a: assert property (tx_valid_ff && tx_leg_ff |-> tx_ff.data[39:0] == 40'h0
        && tx_ff.data[47:44] == 4'h0) else $error("legacy pad bits not zero");
    leg_map_a: assert property (load && leg_pend_ff |=> tx_ff.data[63:56] == $past(active_ff[7:0]))
        else $error("legacy byte 7 mismatch");
    red_force_a: assert property (bus_error |=> red_ff == 20'hfffff)
        else $error("bus error did not light all red");
    red_local_a: assert property (!bus_error |=> (red_ff & ~$past(rsel_ff)) == 20'h0)
        else $error("local red indicator lit");
    green_rx_a: assert property (pri_fb_s |=> ((green_ff ^ $past(pri_on_ff))
        & $past(gsel_ff & ~gsec_ff)) == 20'h0) else $error("green does not follow feedback");
    rx_reject_a: assert property (rx_valid && d[7:0] != RX_MAGIC |=> $stable(pri_on_ff)
        && $stable(sec_flt_ff)) else $error("feedback without marker taken");
    zero_delay_a: assert property (press_now[0] && !active_ff[0] && don_ff[0] == 8'h0
        |-> ##2 active_ff[0]) else $error("zero delay switch not on");
    group_excl_a: assert property (on_keep[1] |=> !mate_act[1] && active_ff[1])
        else $error("group mate still active");
    nosel_hold_a: assert property (press_now[1] && active_ff[1] && !nosel_ff[grp_ff[1]]
        |=> !poff_ff[1]) else $error("forbidden empty selection");
    leg_send_a: assert property (leg_en_ff && chg != 20'h0 |=> leg_pend_ff
        || (tx_valid_ff && tx_leg_ff)) else $error("legacy frame not queued");
endmodule : switch_panel_can_framer
`default_nettype wire

// ### hdl/switch_panel_pkg.sv
// package: map, constants and frame carrier of the switch panel framer
package switch_panel_pkg;
    localparam int NSW  = 20;
    localparam int NPKG = 8;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RXPRI_OFS = 8'h04;
    localparam logic [7:0] RXSEC_OFS = 8'h08;
    localparam logic [7:0] TXID_OFS = 8'h0c;
    localparam logic [7:0] GSEL_OFS = 8'h10;
    localparam logic [7:0] GSEC_OFS = 8'h14;
    localparam logic [7:0] RSEL_OFS = 8'h18;
    localparam logic [7:0] RSEC_OFS = 8'h1c;
    localparam logic [7:0] IDX_OFS = 8'h20;
    localparam logic [7:0] GRP_OFS = 8'h24;
    localparam logic [7:0] DLY_OFS = 8'h28;
    localparam logic [7:0] NOSEL_OFS = 8'h2c;
    localparam logic [7:0] XSEL_OFS = 8'h30;
    localparam logic [7:0] XID_OFS = 8'h34;
    localparam logic [7:0] XVAL_OFS = 8'h38;
    localparam logic [7:0] XSW_OFS = 8'h3c;
    localparam logic [7:0] STAT_OFS = 8'h40;
    localparam logic [7:0] GLED_OFS = 8'h44;
    localparam logic [7:0] RLED_OFS = 8'h48;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int CTRL_LEG_BIT = 0;
    localparam int ID_EXT_BIT = 31;
    localparam int XSW_EN_BIT = 8;
    localparam int DLY_OFF_LSB = 8;
    localparam int XVAL_ON_LSB = 16;
    localparam logic [28:0] ID11_MAX = 29'h00007ff;
    localparam logic [19:0] NOSEL_RST = 20'hfffff;
    localparam logic [7:0] RX_MAGIC = 8'h0a;
    localparam logic [15:0] BYTE_MAX = 16'h00ff;
    localparam logic [3:0] LEG_DLC = 4'h8;
    localparam logic [3:0] WORD_DLC = 4'h2;
    localparam logic [3:0] BYTE_DLC = 4'h1;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int TICK_W = 17;
    typedef struct packed {
        logic        ext;
        logic [28:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } frame_s;
endpackage : switch_panel_pkg

// ### tb/can_node_model.sv
// can node model: remote power controller seen through the can controller
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
    // clock
    input  wire logic                     clk,
    // framer transmit side
    input  wire logic                     tx_valid,
    input  wire switch_panel_pkg::frame_s tx_frame,
    output logic                          tx_ready,
    // framer receive side
    output logic                          rx_valid,
    output switch_panel_pkg::frame_s      rx_frame
);
    import switch_panel_pkg::*;
    // ****************************************
    // transmit acceptance, prompt or slow
    // ****************************************
    logic   slow     = 1'b0;
    int     n_tx     = 0;
    int     wait_cnt = 0;
    frame_s last_tx  = '0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_frame = '0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            last_tx <= tx_frame;
            n_tx <= n_tx + 1;
            tx_ready <= 1'b0;
            wait_cnt <= 0;
        end else if (tx_valid) begin
            wait_cnt <= wait_cnt + 1;
            tx_ready <= !slow || (wait_cnt >= 3);
        end
    end
    // one feedback frame; afterwards the bus no longer shows its data
    task automatic send_feedback(input logic [28:0] id, input logic [63:0] data);
        @(posedge clk);
        rx_frame <= {1'b0, id, LEG_DLC, data};
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;
    endtask : send_feedback
endmodule : can_node_model
`default_nettype wire

// ### tb/testbench.sv
// testbench: registers, legacy transmit, feedback and groups of the framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import switch_panel_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, bus_error;
    logic        rx_valid, tx_valid, tx_ready;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [19:0] sw_pressed, green_led, red_led, switch_state;
    frame_s      rx_frame, tx_frame;
    int          errors = 0;
    int          n_compared = 0;
    switch_panel_can_framer #(.TICK_CYC(4)) dut_u (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sw_pressed(sw_pressed), .rx_valid(rx_valid),
        .rx_frame(rx_frame), .bus_error(bus_error), .tx_frame(tx_frame), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .green_led(green_led), .red_led(red_led), .switch_state(switch_state));
    can_node_model node_u (.clk(clk), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // pready is a one-cycle pulse; it and the read data are taken at one rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk({e, q}, {exp_e, exp});
    endtask : rd
    // press one switch and expect the given legacy payload to go out
    task automatic press(input int i, input logic [63:0] exp_data, input logic [19:0] exp_st);
        int n0;
        int n;
        n0 = node_u.n_tx;
        sw_pressed[i] <= 1'b1;
        repeat (6) @(posedge clk);
        sw_pressed[i] <= 1'b0;
        repeat (12) @(posedge clk);
        chk(switch_state, exp_st);
        if (exp_data != 64'h0) begin
            n = 0;
            while (node_u.n_tx == n0 && n < 60) begin
                @(posedge clk);
                n++;
            end
            if (n >= 60) errors++;
            chk(node_u.last_tx, {1'b0, 29'h123, LEG_DLC, exp_data});
        end
    endtask : press
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reg;
        rd(CTRL_OFS, 32'h0, 1'b0);
        rd(8'h80, 32'h0, 1'b1);
        wr(CTRL_OFS, 32'h1);
        rd(CTRL_OFS, 32'h1, 1'b0);
        wr(TXID_OFS, 32'h0000_1923);
        rd(TXID_OFS, 32'h0000_0123, 1'b0);
        $display("t_reg done");
    endtask : t_reg
    task automatic t_tx;
        press(19, 64'h0000_0800_0000_0000, 20'h80000);
        node_u.slow <= 1'b1;
        press(0, 64'h0100_0800_0000_0000, 20'h80001);
        node_u.slow <= 1'b0;
        rd(STAT_OFS, 32'h0008_0001, 1'b0);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx;
        wr(RXPRI_OFS, 32'h321);
        wr(GSEL_OFS, 32'hfffff);
        wr(RSEL_OFS, 32'hfffff);
        node_u.send_feedback(29'h321, 64'h0200_0800_0180_050a);
        repeat (4) @(posedge clk);
        chk(green_led, 20'h58001);
        chk(red_led, 20'h80002);
        node_u.send_feedback(29'h321, 64'hfdff_f7ff_fe7f_fa0b);
        node_u.send_feedback(29'h322, 64'hfdff_f7ff_fe7f_fa0a);
        repeat (4) @(posedge clk);
        chk({green_led, red_led}, {20'h58001, 20'h80002});
        bus_error <= 1'b1;
        repeat (4) @(posedge clk);
        chk(red_led, 20'hfffff);
        bus_error <= 1'b0;
        repeat (4) @(posedge clk);
        chk(red_led, 20'h80002);
        wr(RSEL_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk(red_led, 20'h0);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_grp;
        wr(IDX_OFS, 32'h1);
        wr(GRP_OFS, 32'h0);
        rd(GRP_OFS, 32'h0, 1'b0);
        press(1, 64'h0200_0800_0000_0000, 20'h80002);
        wr(NOSEL_OFS, 32'h0);
        press(1, 64'h0, 20'h80002);
        wr(NOSEL_OFS, 32'hfffff);
        press(1, 64'h0, 20'h80000);
        $display("t_grp done");
    endtask : t_grp
    task automatic t_extra_export_levels;
        int n0;
        wr(CTRL_OFS, 32'h0);
        wr(XID_OFS, 32'h200);
        wr(XVAL_OFS, 32'h0123_0000);
        wr(XSW_OFS, 32'h102);
        n0 = node_u.n_tx;
        press(2, 64'h0, 20'h80004);
        chk(node_u.last_tx, {1'b0, 29'h200, WORD_DLC, 64'h2301});
        press(2, 64'h0, 20'h80000);
        chk(node_u.n_tx - n0, 1);
        wr(IDX_OFS, 32'h3);
        wr(DLY_OFS, 32'h3);
        sw_pressed[3] <= 1'b1;
        repeat (6) @(posedge clk);
        chk(switch_state[3], 1'b0);
        sw_pressed[3] <= 1'b0;
        repeat (20) @(posedge clk);
        chk(switch_state[3], 1'b1);
        $display("t_extra_export_levels done");
    endtask : t_extra_export_levels
    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, bus_error} = 4'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        sw_pressed = 20'h0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reg();
        t_tx();
        t_rx();
        t_grp();
        t_extra_export_levels();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
